// *** shared/timer_pwm_defs.vh ***
// Register offsets, field positions and reset values of the 8-bit timer.
`ifndef TIMER_PWM_DEFS_VH
`define TIMER_PWM_DEFS_VH
// =========================================================
// Register byte addresses (word aligned)
`define OFS_CTRL_A 6'h00
`define OFS_COUNT 6'h04
`define OFS_COMPARE 6'h08
`define OFS_ASYNC 6'h0c
`define OFS_IRQ_MASK 6'h10
`define OFS_IRQ_FLAG 6'h14
`define OFS_GEN_CTRL 6'h18
// =========================================================
// Control A fields
`define CTRL_FORCE_BIT 7
`define CTRL_WAVE_HI_BIT 6
`define CTRL_WAVE_LO_BIT 3
`define CTRL_ACTION_HI 5
`define CTRL_ACTION_LO 4
`define CTRL_CLKSEL_HI 2
`define CTRL_CLKSEL_LO 0
// Async status fields
`define ASYNC_EXT_EN_BIT 4
`define ASYNC_SEL_BIT 3
`define ASYNC_BUSY_COUNT_BIT 2
`define ASYNC_BUSY_CMP_BIT 1
`define ASYNC_BUSY_CTRL_BIT 0
// Interrupt mask and flag fields
`define IRQ_COMPARE_BIT 1
`define IRQ_OVERFLOW_BIT 0
// General control fields
`define GEN_HOLD_BIT 7
`define GEN_PRESCALE_CLR_BIT 1
// =========================================================
// Modes, reset value and counter limits
`define MODE_NORMAL 2'h0
`define MODE_PHASE 2'h1
`define MODE_CTC 2'h2
`define MODE_FAST 2'h3
`define REG_RESET 8'h00
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define PRESCALE_W 10
`endif

// *** src/osc_edge_sync.v ***
// Two-stage synchroniser for the oscillator pin with rising-edge pulse.
`default_nettype none
module osc_edge_sync (
  input wire clk,
  input wire nrst,
  input wire pin_in,
  output reg rise_pulse
);
  // =========================================================
  // Synchroniser
  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;

  // Only the second and third stages feed the edge detector, keeping the first clean.
  always @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      rise_pulse <= sync2_reg & ~sync3_reg;
    end
  end
endmodule // osc_edge_sync
`default_nettype wire

// *** src/async_timer_pwm_8bit.v ***
// Main body of the 8-bit timer with compare channel, PWM and async clocking.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
`include "timer_pwm_defs.vh"
module async_timer_pwm_8bit (
  input wire clk,
  input wire nrst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire osc_in_pin,
  input wire global_irq_en,
  input wire compare_vector_ack,
  input wire overflow_vector_ack,
  input wire pin_dir,
  input wire port_data,
  output wire compare_irq,
  output wire overflow_irq,
  output wire pin_out,
  output wire pin_oe,
  output wire crystal_osc_en
);
  // =========================================================
  // Registers
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_tmp_reg;
  reg [7:0] count_reg;
  reg [7:0] count_tmp_reg;
  reg [7:0] compare_reg;
  reg [7:0] compare_tmp_reg;
  reg [4:3] async_cfg_reg;
  reg [2:0] busy_reg;
  reg [1:0] edge_cnt_reg [0:2];
  reg [1:0] irq_en_reg;
  reg [1:0] flag_reg;
  reg hold_reg;
  reg prescale_clr_reg;
  reg [`PRESCALE_W-1:0] prescale_reg;
  reg [`PRESCALE_W-1:0] prescale_prev_reg;
  reg out_reg;
  reg down_reg;
  reg block_reg;
  reg ack_reg;
  wire osc_rise;

  // =========================================================
  // Oscillator input, synchronised before any use.
  osc_edge_sync u_osc_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(osc_in_pin),
    .rise_pulse(osc_rise)
  );

  // Source clock tick: every clk, or each oscillator rising edge.
  wire async_mode = async_cfg_reg[`ASYNC_SEL_BIT];
  wire src_tick = async_mode ? osc_rise : 1'b1;
  // The crystal runs only without the external clock input.
  assign crystal_osc_en = async_mode & ~async_cfg_reg[`ASYNC_EXT_EN_BIT];

  // Two-cycle Avalon slave: one wait cycle, then acknowledge.
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  wire wr_go = avs_write & ack_reg & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_ctrl = wr_go & (avs_address == `OFS_CTRL_A);
  wire wr_count = wr_go & (avs_address == `OFS_COUNT);
  wire wr_cmp = wr_go & (avs_address == `OFS_COMPARE);

  // =========================================================
  // Mode decode and prescaler taps.
  wire [1:0] mode = {ctrl_reg[`CTRL_WAVE_HI_BIT], ctrl_reg[`CTRL_WAVE_LO_BIT]};
  wire [1:0] action = ctrl_reg[`CTRL_ACTION_HI:`CTRL_ACTION_LO];
  wire [2:0] csel = ctrl_reg[`CTRL_CLKSEL_HI:`CTRL_CLKSEL_LO];
  wire pwm_mode = (mode == `MODE_PHASE) | (mode == `MODE_FAST);
  wire [7:0] top = (mode == `MODE_CTC) ? compare_reg : `COUNT_MAX;
  // A falling edge of a tap bit marks the end of a divided period.
  wire [`PRESCALE_W-1:0] tap_fall = prescale_prev_reg & ~prescale_reg;
  reg tick_sel;

  // Taps 2,4,5,6,7,9 give divide by 8,32,64,128,256,1024.
  always @* begin
    case (csel)
      3'h0: tick_sel = 1'b0;
      3'h1: tick_sel = src_tick;
      3'h2: tick_sel = tap_fall[2];
      3'h3: tick_sel = tap_fall[4];
      3'h4: tick_sel = tap_fall[5];
      3'h5: tick_sel = tap_fall[6];
      3'h6: tick_sel = tap_fall[7];
      default: tick_sel = tap_fall[9];
    endcase
  end
  wire timer_tick = tick_sel;

  // Compare match, blocked for one timer tick after a count write.
  wire match_raw = (count_reg == compare_reg);
  wire match = timer_tick & match_raw & ~block_reg;
  wire at_top = count_reg == top;
  // Compare at TOP with upper action bit moves the action to BOTTOM or TOP.
  wire top_special = pwm_mode & action[1] & (compare_reg == `COUNT_MAX);
  // The strobe obeys the mode and action written with it, so one write can select and force.
  wire force_go = wr_ctrl & wd[`CTRL_FORCE_BIT] & ~wd[`CTRL_WAVE_LO_BIT];
  wire [1:0] fire_action = force_go ? wd[`CTRL_ACTION_HI:`CTRL_ACTION_LO] : action;

  // =========================================================
  // Output waveform next state.
  reg out_next;
  always @* begin
    out_next = out_reg;
    if (force_go | (match & ~pwm_mode)) begin
      case (fire_action)
        2'h1: out_next = ~out_reg;
        2'h2: out_next = 1'b0;
        2'h3: out_next = 1'b1;
        default: out_next = out_reg;
      endcase
    end else if (timer_tick & action[1] & (mode == `MODE_FAST)) begin
      if (match & ~top_special) begin
        out_next = action[0];
      end else if (at_top) begin
        out_next = ~action[0];
      end
    end else if (timer_tick & action[1] & (mode == `MODE_PHASE)) begin
      if (top_special & at_top) begin
        out_next = down_reg ? ~action[0] : action[0];
      end else if (match & ~top_special) begin
        out_next = down_reg ? ~action[0] : action[0];
      end
    end
  end

  // Pin override by the waveform when any action bit is set.
  assign pin_out = (action != 2'h0) ? out_reg : port_data;
  assign pin_oe = pin_dir;

  // Interrupt requests gated by enable and global bit.
  assign compare_irq = global_irq_en & irq_en_reg[`IRQ_COMPARE_BIT] & flag_reg[1];
  assign overflow_irq = global_irq_en & irq_en_reg[`IRQ_OVERFLOW_BIT] & flag_reg[0];

  // =========================================================
  // Counter, flags and waveform.
  wire count_load = async_mode ? (busy_reg[2] & osc_rise & (edge_cnt_reg[2] == 2'h1)) : wr_count;
  wire [7:0] count_load_val = async_mode ? count_tmp_reg : wd;
  wire ovf_event = timer_tick & ((mode == `MODE_PHASE) ?
    (down_reg & (count_reg == 8'h01)) : (count_reg == `COUNT_MAX));
  wire cmp_event = match; // Force strobe never reaches here.
  wire flag_clr_wr = wr_go & (avs_address == `OFS_IRQ_FLAG);

  always @(posedge clk) begin
    if (!nrst) begin
      count_reg <= `REG_RESET;
      down_reg <= 1'b0;
      out_reg <= 1'b0;
      block_reg <= 1'b0;
      flag_reg <= 2'h0;
    end else begin
      out_reg <= out_next;
      if (count_load) begin
        count_reg <= count_load_val;
        block_reg <= 1'b1;
      end else if (timer_tick) begin
        block_reg <= 1'b0;
        if (mode == `MODE_PHASE) begin
          if (!down_reg && at_top) begin
            down_reg <= 1'b1;
            count_reg <= count_reg - 8'h01;
          end else if (down_reg && count_reg == 8'h01) begin
            down_reg <= 1'b0;
            count_reg <= `COUNT_BOTTOM;
          end else begin
            count_reg <= down_reg ? count_reg - 8'h01 : count_reg + 8'h01;
          end
        end else if (mode == `MODE_CTC && match) begin
          count_reg <= `COUNT_BOTTOM;
        end else begin
          down_reg <= 1'b0;
          count_reg <= at_top ? `COUNT_BOTTOM : count_reg + 8'h01;
        end
      end
      // Set beats clear on the same cycle.
      flag_reg[1] <= cmp_event |
        (flag_reg[1] & ~(compare_vector_ack | (flag_clr_wr & wd[1])));
      flag_reg[0] <= ovf_event |
        (flag_reg[0] & ~(overflow_vector_ack | (flag_clr_wr & wd[0])));
    end
  end

  // =========================================================
  // Compare buffer: immediate in normal and CTC, at TOP in both PWM modes.
  wire cmp_src_ready = async_mode ? (busy_reg[1] ? 1'b0 : 1'b1) : 1'b1;
  wire cmp_update = (mode == `MODE_NORMAL) | (mode == `MODE_CTC) |
    (timer_tick & (mode == `MODE_PHASE) & at_top & ~down_reg) |
    (timer_tick & (mode == `MODE_FAST) & at_top);

  always @(posedge clk) begin
    if (!nrst) begin
      compare_reg <= `REG_RESET;
      ctrl_reg <= `REG_RESET;
    end else begin
      if (cmp_src_ready & cmp_update) begin
        compare_reg <= compare_tmp_reg;
      end
      if (async_mode ? (busy_reg[0] & osc_rise & (edge_cnt_reg[0] == 2'h1)) : wr_ctrl) begin
        ctrl_reg <= {1'b0, async_mode ? ctrl_tmp_reg[6:0] : wd[6:0]};
      end
    end
  end

  // =========================================================
  // Temporary registers and busy flags, one per target, independent.
  wire [2:0] wr_vec = {wr_count, wr_cmp, wr_ctrl};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_busy
      // Busy holds until the second oscillator rise after the write.
      always @(posedge clk) begin
        if (!nrst) begin
          busy_reg[gi] <= 1'b0;
          edge_cnt_reg[gi] <= 2'h0;
        end else if (wr_vec[gi] & async_mode) begin
          busy_reg[gi] <= 1'b1;
          edge_cnt_reg[gi] <= 2'h0;
        end else if (busy_reg[gi] & osc_rise) begin
          if (edge_cnt_reg[gi] == 2'h1) begin
            busy_reg[gi] <= 1'b0;
          end
          edge_cnt_reg[gi] <= edge_cnt_reg[gi] + 2'h1;
        end
      end
    end
  endgenerate

  // Temporaries also mirror synchronous writes so control and compare reads always see them; count reads return count_reg.
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_tmp_reg <= `REG_RESET;
      count_tmp_reg <= `REG_RESET;
      compare_tmp_reg <= `REG_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_tmp_reg <= {1'b0, wd[6:0]};
      end
      if (wr_count) begin
        count_tmp_reg <= wd;
      end
      if (wr_cmp) begin
        compare_tmp_reg <= wd;
      end
    end
  end

  // =========================================================
  // Prescaler, cleared on request; request lingers in async mode.
  always @(posedge clk) begin
    if (!nrst) begin
      prescale_reg <= {`PRESCALE_W{1'b0}};
      prescale_prev_reg <= {`PRESCALE_W{1'b0}};
      prescale_clr_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      prescale_prev_reg <= prescale_reg;
      if (prescale_clr_reg) begin
        prescale_reg <= {`PRESCALE_W{1'b0}};
        prescale_prev_reg <= {`PRESCALE_W{1'b0}};
      end else if (src_tick) begin
        prescale_reg <= prescale_reg + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
      end
      if (wr_go & (avs_address == `OFS_GEN_CTRL)) begin
        hold_reg <= wd[`GEN_HOLD_BIT];
        prescale_clr_reg <= wd[`GEN_PRESCALE_CLR_BIT] | prescale_clr_reg;
      end else if (prescale_clr_reg & ~hold_reg & (~async_mode | osc_rise)) begin
        prescale_clr_reg <= 1'b0;
      end
    end
  end

  // =========================================================
  // Bus handshake and remaining software registers.
  always @(posedge clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      irq_en_reg <= 2'h0;
      async_cfg_reg <= 2'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (wr_go & (avs_address == `OFS_IRQ_MASK)) begin
        irq_en_reg <= wd[1:0];
      end
      if (wr_go & (avs_address == `OFS_ASYNC)) begin
        async_cfg_reg <= wd[4:3];
      end
    end
  end

  // Read data registered in the wait cycle, ready on the acknowledge cycle; unmapped reads zero.
  always @(posedge clk) begin
    if (!nrst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_reg) begin
      case (avs_address)
        `OFS_CTRL_A: avs_readdata <= {24'h000000, 1'b0, ctrl_tmp_reg[6:0]};
        `OFS_COUNT: avs_readdata <= {24'h000000, count_reg};
        `OFS_COMPARE: avs_readdata <= {24'h000000, compare_tmp_reg};
        `OFS_ASYNC: avs_readdata <= {24'h000000, 3'h0, async_cfg_reg, busy_reg};
        `OFS_IRQ_MASK: avs_readdata <= {24'h000000, 6'h00, irq_en_reg};
        `OFS_IRQ_FLAG: avs_readdata <= {24'h000000, 6'h00, flag_reg};
        `OFS_GEN_CTRL: avs_readdata <= {24'h000000, hold_reg, 5'h00, prescale_clr_reg, 1'b0};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule // async_timer_pwm_8bit
`default_nettype wire

// *** bench/timer_pwm_sva.sv ***
// Concurrent checks on the bus handshake, read data, pin enable and interrupt outputs of the timer.
`default_nettype none
`include "timer_pwm_defs.vh"
// =========================================================
// Checker module
module timer_pwm_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic global_irq_en,
  input wire logic pin_dir,
  input wire logic pin_oe,
  input wire logic compare_irq,
  input wire logic overflow_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks share the one clock; all but reset_clear_a are disabled by the synchronous reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  wait_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not acknowledged in second cycle");
  idle_no_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without request");
  read_force_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == `OFS_CTRL_A |-> avs_readdata[7] == 1'b0)
    else $error("force strobe read back as one");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address > `OFS_GEN_CTRL |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  pin_enable_a: assert property (pin_oe == pin_dir)
    else $error("pin driver enable differs from direction bit");
  irq_gate_a: assert property (!global_irq_en |-> !compare_irq && !overflow_irq)
    else $error("interrupt requested with global bit clear");
  // Reset is checked while it is applied, so this one is never disabled.
  reset_clear_a: assert property (disable iff (1'b0)
    !nrst |=> avs_readdata == 32'h0 && !compare_irq && !overflow_irq)
    else $error("outputs not cleared by reset");
endmodule // timer_pwm_sva
bind async_timer_pwm_8bit timer_pwm_sva u_timer_pwm_sva (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_irq_en(global_irq_en), .pin_dir(pin_dir), .pin_oe(pin_oe),
  .compare_irq(compare_irq), .overflow_irq(overflow_irq));
`default_nettype wire

// *** bench/async_timer_pwm_8bit_bench.sv ***
// Self-checking bench for the 8-bit timer with compare channel.
`default_nettype none
`include "timer_pwm_defs.vh"
// =========================================================
// Bench top
module async_timer_pwm_8bit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [3:0] osc_cnt = 4'h0;
  logic global_irq_en = 1'b1;
  logic compare_vector_ack = 1'b0;
  logic overflow_vector_ack = 1'b0;
  logic pin_dir = 1'b1;
  logic port_data = 1'b0;
  logic [31:0] rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, compare_irq, overflow_irq, pin_out, pin_oe, crystal_osc_en;
  int fails = 0;
  int checks = 0;
  int n;
  int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  async_timer_pwm_8bit u_async_timer_pwm_8bit (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_in_pin(osc_cnt[3]), .global_irq_en(global_irq_en),
    .compare_vector_ack(compare_vector_ack), .overflow_vector_ack(overflow_vector_ack),
    .pin_dir(pin_dir), .port_data(port_data), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe(pin_oe),
    .crystal_osc_en(crystal_osc_en));
  // Clock, and a free-running oscillator 16 times slower so sync stays safe.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 4'h1;
  end
  // One bus access: held until waitrequest is seen low, then released.
  task automatic bus(input logic is_wr, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !is_wr;
    avs_write <= is_wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++k < 50);
    if (k >= 50)
      chk("bus_wait", 8'h00, 8'h01);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rd[7:0]);
  endtask
  // Pin is looked at after the force or write has had two edges to land.
  task automatic pin(input string nm, input logic e);
    repeat (2) @(posedge clk);
    chk(nm, {7'h0, e}, {7'h0, pin_out});
  endtask
  // Counts high cycles of the waveform over 1024 cycles after a warm-up.
  task automatic duty(input logic [7:0] ctl, input logic [7:0] cmp, input int e);
    int hi;
    hi = 0;
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_COUNT, 8'h00);
    wr(`OFS_COMPARE, cmp);
    wr(`OFS_CTRL_A, ctl);
    repeat (600) @(posedge clk);
    repeat (1024) begin
      @(posedge clk);
      hi += (pin_out === 1'b1);
    end
    chk("duty", 8'h1, {7'h0, hi > e - 24 && hi < e + 24});
  endtask
  task automatic results;
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence of register tests.
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdchk(6'(i * 4), 8'h00, "reset_val");
    wr(`OFS_CTRL_A, 8'hb0);
    pin("force_set", 1'b1);
    wr(`OFS_CTRL_A, 8'ha0);
    pin("force_clear", 1'b0);
    wr(`OFS_CTRL_A, 8'h90);
    pin("force_tgl1", 1'b1);
    wr(`OFS_CTRL_A, 8'h90);
    pin("force_tgl2", 1'b0);
    rdchk(`OFS_IRQ_FLAG, 8'h00, "force_noflag");
    port_data <= 1'b1;
    wr(`OFS_CTRL_A, 8'h00);
    pin("disconnect", 1'b1);
    port_data <= 1'b0;
    pin_dir <= 1'b0;
    @(posedge clk);
    chk("pin_oe", 8'h0, {7'h0, pin_oe});
    pin_dir <= 1'b1;
    wr(`OFS_CTRL_A, 8'hb0);
    wr(`OFS_CTRL_A, 8'he8);
    pin("pwm_noforce", 1'b1);
    rdchk(`OFS_CTRL_A, 8'h68, "ctrl_read");
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_COUNT, 8'h5a);
    avs_byteenable <= 4'he;
    wr(`OFS_COUNT, 8'h11);
    avs_byteenable <= 4'hf;
    rdchk(`OFS_COUNT, 8'h5a, "count_rw");
    wr(`OFS_COMPARE, 8'h10);
    wr(`OFS_IRQ_MASK, 8'h03);
    wr(`OFS_COUNT, 8'h00);
    wr(`OFS_CTRL_A, 8'h01);
    repeat (40) @(posedge clk);
    wr(`OFS_CTRL_A, 8'h00);
    rdchk(`OFS_IRQ_FLAG, 8'h02, "cmp_flag");
    chk("cmp_irq", 8'h1, {7'h0, compare_irq});
    global_irq_en <= 1'b0;
    @(posedge clk);
    chk("irq_gate", 8'h0, {7'h0, compare_irq});
    global_irq_en <= 1'b1;
    wr(`OFS_IRQ_FLAG, 8'h02);
    rdchk(`OFS_IRQ_FLAG, 8'h00, "cmp_w1c");
    // The match on the first tick after a count write must be swallowed.
    wr(`OFS_COMPARE, 8'h05);
    wr(`OFS_COUNT, 8'h05);
    wr(`OFS_CTRL_A, 8'h01);
    repeat (20) @(posedge clk);
    wr(`OFS_CTRL_A, 8'h00);
    rdchk(`OFS_IRQ_FLAG, 8'h00, "cmp_blocked");
    wr(`OFS_COMPARE, 8'h80);
    wr(`OFS_COUNT, 8'hf0);
    wr(`OFS_CTRL_A, 8'h01);
    repeat (40) @(posedge clk);
    wr(`OFS_CTRL_A, 8'h00);
    rdchk(`OFS_IRQ_FLAG, 8'h01, "ovf_flag");
    chk("ovf_irq", 8'h1, {7'h0, overflow_irq});
    overflow_vector_ack <= 1'b1;
    @(posedge clk);
    overflow_vector_ack <= 1'b0;
    rdchk(`OFS_IRQ_FLAG, 8'h00, "ovf_ack");
    wr(`OFS_COMPARE, 8'h20);
    wr(`OFS_COUNT, 8'h00);
    wr(`OFS_CTRL_A, 8'h41);
    repeat (300) @(posedge clk);
    wr(`OFS_CTRL_A, 8'h00);
    bus(1'b0, `OFS_COUNT, 8'h00);
    chk("ctc_top", 8'h1, {7'h0, rd[7:0] <= 8'h20});
    compare_vector_ack <= 1'b1;
    @(posedge clk);
    compare_vector_ack <= 1'b0;
    rdchk(`OFS_IRQ_FLAG, 8'h00, "cmp_ack");
    for (int cs = 2; cs < 8; cs++) begin
      wr(`OFS_COUNT, 8'h00);
      wr(`OFS_CTRL_A, 8'(cs));
      repeat (4 * dv[cs]) @(posedge clk);
      wr(`OFS_CTRL_A, 8'h00);
      bus(1'b0, `OFS_COUNT, 8'h00);
      chk("prescale", 8'h1, {7'h0, rd[7:0] >= 8'h03 && rd[7:0] <= 8'h05});
    end
    duty(8'h69, 8'h40, 260);
    duty(8'h79, 8'h40, 764);
    duty(8'h29, 8'h40, 257);
    duty(8'h39, 8'h40, 767);
    duty(8'h69, 8'hff, 1024);
    wr(`OFS_CTRL_A, 8'h00);
    wr(`OFS_ASYNC, 8'h08);
    chk("osc_on", 8'h1, {7'h0, crystal_osc_en});
    wr(`OFS_ASYNC, 8'h18);
    chk("osc_off", 8'h0, {7'h0, crystal_osc_en});
    wr(`OFS_ASYNC, 8'h08);
    wr(`OFS_COMPARE, 8'h33);
    rdchk(`OFS_ASYNC, 8'h0a, "busy_set");
    n = 0;
    // Software polls the busy flag before touching the register again.
    while (rd[1] !== 1'b0 && n < 40) begin
      bus(1'b0, `OFS_ASYNC, 8'h00);
      n++;
    end
    chk("busy_span", 8'h1, {7'h0, n >= 4 && n < 40});
    rdchk(`OFS_COMPARE, 8'h33, "cmp_async");
    wr(`OFS_ASYNC, 8'h00);
    wr(`OFS_GEN_CTRL, 8'h02);
    rdchk(`OFS_GEN_CTRL, 8'h00, "psc_clear");
    wr(`OFS_GEN_CTRL, 8'h82);
    rdchk(`OFS_GEN_CTRL, 8'h82, "psc_hold");
    wr(`OFS_GEN_CTRL, 8'h00);
    results();
  end
  // Watchdog well beyond the roughly 15000 cycles the tests need.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    results();
  end
endmodule // async_timer_pwm_8bit_bench
`default_nettype wire
